// ### pkg/ktp_cfg.svh
// constants for the four-lane training processor port, both ends
`ifndef KTP_CFG_SVH
`define KTP_CFG_SVH

`define KTP_LANES          4
`define KTP_TAP_W          2
`define KTP_TAP_NONE       2'h0
`define KTP_TAP_MAIN       2'h1
`define KTP_TAP_POST       2'h2
`define KTP_TAP_PRE        2'h3
`define KTP_BER_CNT_W      4
`define KTP_BER_TIMER_W    16
`define KTP_BER_TIMER_MAX  16'hFFFF
`define KTP_BER_TIMER_ONE  16'h0001
`define KTP_BER_TIMER_RST  16'h0000
`define KTP_ENABLE_PROC_IF 1'b1

`endif

// ### pkg/ktp_pkg.sv
// shared types for the training processor port
package ktp_pkg;

  // coefficient request kinds sent towards the link partner
  typedef enum logic [2:0] {
    KTP_OP_HOLD,
    KTP_OP_INC,
    KTP_OP_DEC,
    KTP_OP_PRESET,
    KTP_OP_INIT
  } ktp_op_t;

endpackage : ktp_pkg

// ### pkg/ktp_if.sv
// interface joining the processor end and the core end
`timescale 1ns/1ps
`include "ktp_cfg.svh"

interface ktp_if #(
  parameter int LANES = `KTP_LANES,
  parameter int BCW   = `KTP_BER_CNT_W
);
  logic [LANES-1:0]           proc_mode_en;
  logic [LANES*`KTP_TAP_W-1:0] proc_tap_sel;
  logic [LANES-1:0]           proc_inc;
  logic [LANES-1:0]           proc_dec;
  logic [LANES-1:0]           proc_preset;
  logic [LANES-1:0]           proc_init;
  logic [LANES-1:0]           proc_ber_timer_start;
  logic [LANES-1:0]           proc_train_err;
  logic [LANES-1:0]           proc_lock_err;
  logic [LANES-1:0]           proc_rx_trained;
  logic [LANES-1:0]           core_cmd_ready;
  logic [LANES-1:0]           core_frame_lock;
  logic [LANES-1:0]           core_command_done;
  logic [LANES-1:0]           core_ber_timer_done;
  logic [LANES*BCW-1:0]       core_ber_cnt;
  logic [LANES-1:0]           core_ber_overflow;
  logic [LANES-1:0]           core_coef_limit;

  modport dev (
    input  proc_mode_en, proc_tap_sel, proc_inc, proc_dec, proc_preset, proc_init,
    input  proc_ber_timer_start, proc_train_err, proc_lock_err, proc_rx_trained,
    output core_cmd_ready, core_frame_lock, core_command_done, core_ber_timer_done,
    output core_ber_cnt, core_ber_overflow, core_coef_limit
  );

  modport proc (
    output proc_mode_en, proc_tap_sel, proc_inc, proc_dec, proc_preset, proc_init,
    output proc_ber_timer_start, proc_train_err, proc_lock_err, proc_rx_trained,
    input  core_cmd_ready, core_frame_lock, core_command_done, core_ber_timer_done,
    input  core_ber_cnt, core_ber_overflow, core_coef_limit
  );
endinterface : ktp_if

// ### rtl/ktp_core_end.sv
// core end of the training processor port: command handshake, BER timer, status
`timescale 1ns/1ps
`include "ktp_cfg.svh"

module ktp_core_end #(
  parameter int                        LANES         = `KTP_LANES,
  parameter int                        BCW           = `KTP_BER_CNT_W,
  parameter int                        TIMER_W       = `KTP_BER_TIMER_W,
  parameter logic [TIMER_W-1:0]        BER_TIMER_MAX = `KTP_BER_TIMER_MAX,
  parameter bit                        ENABLE_PROC   = `KTP_ENABLE_PROC_IF
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  ktp_if.dev                           bus,
  input  wire logic [LANES-1:0]        adapt_req_valid,
  input  ktp_pkg::ktp_op_t             adapt_req_op [LANES],
  input  wire logic [LANES*2-1:0]      adapt_req_tap,
  output logic      [LANES-1:0]        adapt_req_ack,
  output logic      [LANES-1:0]        link_req_valid,
  output ktp_pkg::ktp_op_t             link_req_op [LANES],
  output logic      [LANES*2-1:0]      link_req_tap,
  input  wire logic [LANES-1:0]        link_req_ack,
  input  wire logic [LANES-1:0]        rx_frame_lock,
  input  wire logic [LANES-1:0]        rx_bit_err,
  input  wire logic [LANES-1:0]        lp_coef_limit,
  output logic      [LANES-1:0]        lane_proc_mode,
  output logic      [LANES-1:0]        lane_train_err,
  output logic      [LANES-1:0]        lane_lock_err,
  output logic      [LANES-1:0]        lane_rx_trained
);

  typedef enum logic [1:0] {
    D_IDLE,
    D_REQ,
    D_DONE
  } ktp_dstate_t;

  // priority when several command bits rise together: init, preset, inc, dec
  function automatic ktp_pkg::ktp_op_t ktp_cmd_decode(input logic init_b,
                                                      input logic pre_b,
                                                      input logic inc_b,
                                                      input logic dec_b);
    ktp_pkg::ktp_op_t op;
    op = ktp_pkg::KTP_OP_HOLD;
    if (init_b) begin
      op = ktp_pkg::KTP_OP_INIT;
    end else if (pre_b) begin
      op = ktp_pkg::KTP_OP_PRESET;
    end else if (inc_b) begin
      op = ktp_pkg::KTP_OP_INC;
    end else if (dec_b) begin
      op = ktp_pkg::KTP_OP_DEC;
    end
    return op;
  endfunction : ktp_cmd_decode

  // only the three coded taps are valid targets for inc and dec
  function automatic logic ktp_tap_ok(input logic [1:0] tap);
    return (tap == `KTP_TAP_MAIN) || (tap == `KTP_TAP_POST) || (tap == `KTP_TAP_PRE);
  endfunction : ktp_tap_ok

  logic [LANES-1:0]     rdy_r;
  logic [LANES-1:0]     lock_r;
  logic [LANES-1:0]     done_r;
  logic [LANES-1:0]     tdone_r;
  logic [LANES-1:0]     ovf_r;
  logic [LANES-1:0]     limit_r;
  logic [LANES*BCW-1:0] cnt_r;

  assign bus.core_cmd_ready      = rdy_r;
  assign bus.core_frame_lock     = lock_r;
  assign bus.core_command_done   = done_r;
  assign bus.core_ber_timer_done = tdone_r;
  assign bus.core_ber_cnt        = cnt_r;
  assign bus.core_ber_overflow   = ovf_r;
  assign bus.core_coef_limit     = limit_r;

  genvar g;
  generate
    if (ENABLE_PROC) begin : g_port
      for (g = 0; g < LANES; g++) begin : g_lane
        ktp_dstate_t        st_r;
        logic               start_q_r;
        logic               run_r;
        logic [TIMER_W-1:0] timer_r;
        logic               mode;
        logic               any_cmd;
        logic [1:0]         tap;
        logic               start_edge;
        ktp_pkg::ktp_op_t   cmd_op;

        // lane slice of every four-lane bus
        assign mode       = bus.proc_mode_en[g];
        assign tap        = bus.proc_tap_sel[g*2 +: 2];
        assign any_cmd    = bus.proc_inc[g] | bus.proc_dec[g] |
                            bus.proc_preset[g] | bus.proc_init[g];
        assign cmd_op     = ktp_cmd_decode(bus.proc_init[g], bus.proc_preset[g],
                                           bus.proc_inc[g], bus.proc_dec[g]);
        assign start_edge = bus.proc_ber_timer_start[g] & ~start_q_r;

        // command handshake; leaving processor mode abandons any open request
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            st_r                <= D_IDLE;
            link_req_valid[g]   <= 1'b0;
            link_req_op[g]      <= ktp_pkg::KTP_OP_HOLD;
            link_req_tap[g*2 +: 2] <= `KTP_TAP_NONE;
            adapt_req_ack[g]    <= 1'b0;
            done_r[g]           <= 1'b0;
          end else if (ce) begin
            adapt_req_ack[g] <= 1'b0;
            if (!mode) begin
              // internal adaptation owns the request path outside processor mode
              st_r                   <= D_IDLE;
              done_r[g]              <= 1'b0;
              link_req_valid[g]      <= adapt_req_valid[g];
              link_req_op[g]         <= adapt_req_op[g];
              link_req_tap[g*2 +: 2] <= adapt_req_tap[g*2 +: 2];
              adapt_req_ack[g]       <= link_req_ack[g];
            end else begin
              unique case (st_r)
                D_IDLE: begin
                  // internal adaptation requests are ignored here
                  link_req_valid[g] <= 1'b0;
                  if (any_cmd) begin
                    link_req_op[g]         <= cmd_op;
                    link_req_tap[g*2 +: 2] <= tap;
                    if ((cmd_op == ktp_pkg::KTP_OP_INC || cmd_op == ktp_pkg::KTP_OP_DEC)
                        && !ktp_tap_ok(tap)) begin
                      // no tap to act on: finish at once without a request
                      done_r[g] <= 1'b1;
                      st_r      <= D_DONE;
                    end else begin
                      link_req_valid[g] <= 1'b1;
                      st_r              <= D_REQ;
                    end
                  end
                end
                D_REQ: begin
                  if (link_req_ack[g]) begin
                    link_req_valid[g] <= 1'b0;
                    done_r[g]         <= 1'b1;
                    st_r              <= D_DONE;
                  end
                end
                D_DONE: begin
                  // done stays up until the processor lets go of every command bit
                  if (!any_cmd) begin
                    done_r[g] <= 1'b0;
                    st_r      <= D_IDLE;
                  end
                end
              endcase
            end
          end
        end

        // ready only in idle with no command pending, so a held command is not seen twice
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            rdy_r[g] <= 1'b0;
          end else if (ce) begin
            rdy_r[g] <= mode && (st_r == D_IDLE) && !any_cmd;
          end
        end

        // BER timer and error counter, restarted on a rising start bit
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            start_q_r          <= 1'b0;
            run_r              <= 1'b0;
            timer_r            <= `KTP_BER_TIMER_RST;
            tdone_r[g]         <= 1'b0;
            cnt_r[g*BCW +: BCW] <= '0;
            ovf_r[g]           <= 1'b0;
          end else if (ce) begin
            start_q_r <= bus.proc_ber_timer_start[g];
            if (start_edge) begin
              run_r      <= 1'b1;
              timer_r    <= `KTP_BER_TIMER_RST;
              tdone_r[g] <= 1'b0;
              // an error in the start cycle belongs to the new run
              cnt_r[g*BCW +: BCW] <= {{(BCW-1){1'b0}}, rx_bit_err[g]};
              ovf_r[g]            <= 1'b0;
            end else if (run_r) begin
              if (timer_r == BER_TIMER_MAX) begin
                run_r      <= 1'b0;
                tdone_r[g] <= 1'b1;
              end else begin
                timer_r <= timer_r + `KTP_BER_TIMER_ONE;
              end
              if (rx_bit_err[g]) begin
                cnt_r[g*BCW +: BCW] <= cnt_r[g*BCW +: BCW] + 1'b1;
                if (&cnt_r[g*BCW +: BCW]) begin
                  ovf_r[g] <= 1'b1;
                end
              end
            end
          end
        end

        // status flags and processor verdicts, one register stage each
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            lock_r[g]          <= 1'b0;
            limit_r[g]         <= 1'b0;
            lane_proc_mode[g]  <= 1'b0;
            lane_train_err[g]  <= 1'b0;
            lane_lock_err[g]   <= 1'b0;
            lane_rx_trained[g] <= 1'b0;
          end else if (ce) begin
            lock_r[g]          <= rx_frame_lock[g];
            limit_r[g]         <= lp_coef_limit[g];
            lane_proc_mode[g]  <= mode;
            lane_train_err[g]  <= bus.proc_train_err[g];
            lane_lock_err[g]   <= bus.proc_lock_err[g];
            lane_rx_trained[g] <= bus.proc_rx_trained[g];
          end
        end
      end
    end else begin : g_no_port
      // port absent: status reads zero and adaptation runs alone
      for (g = 0; g < LANES; g++) begin : g_lane
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            link_req_valid[g]      <= 1'b0;
            link_req_op[g]         <= ktp_pkg::KTP_OP_HOLD;
            link_req_tap[g*2 +: 2] <= `KTP_TAP_NONE;
            adapt_req_ack[g]       <= 1'b0;
          end else if (ce) begin
            link_req_valid[g]      <= adapt_req_valid[g];
            link_req_op[g]         <= adapt_req_op[g];
            link_req_tap[g*2 +: 2] <= adapt_req_tap[g*2 +: 2];
            adapt_req_ack[g]       <= link_req_ack[g];
          end
        end
      end
      assign rdy_r           = '0;
      assign lock_r          = '0;
      assign done_r          = '0;
      assign tdone_r         = '0;
      assign ovf_r           = '0;
      assign limit_r         = '0;
      assign cnt_r           = '0;
      assign lane_proc_mode  = '0;
      assign lane_train_err  = '0;
      assign lane_lock_err   = '0;
      assign lane_rx_trained = '0;
    end
  endgenerate

endmodule : ktp_core_end

// ### rtl/ktp_proc_end.sv
// processor end of the training processor port: per-lane command sequencer
`timescale 1ns/1ps
`include "ktp_cfg.svh"

module ktp_proc_end #(
  parameter int                        LANES = `KTP_LANES
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  ktp_if.proc                          bus,
  input  wire logic [LANES-1:0]        usr_mode_en,
  input  wire logic [LANES*2-1:0]      usr_tap_sel,
  input  wire logic [LANES-1:0]        usr_cmd_valid,
  input  ktp_pkg::ktp_op_t             usr_cmd_op [LANES],
  output logic      [LANES-1:0]        usr_cmd_busy,
  output logic      [LANES-1:0]        usr_cmd_ack,
  input  wire logic [LANES-1:0]        usr_ber_start,
  input  wire logic [LANES-1:0]        usr_train_err,
  input  wire logic [LANES-1:0]        usr_lock_err,
  input  wire logic [LANES-1:0]        usr_rx_trained
);

  typedef enum logic [1:0] {
    P_IDLE,
    P_WAIT_RDY,
    P_HOLD,
    P_RELEASE
  } ktp_pstate_t;

  logic [LANES-1:0]   mode_r;
  logic [LANES*2-1:0] tap_r;
  logic [LANES-1:0]   inc_r;
  logic [LANES-1:0]   dec_r;
  logic [LANES-1:0]   pre_r;
  logic [LANES-1:0]   init_r;
  logic [LANES-1:0]   start_r;
  logic [LANES-1:0]   terr_r;
  logic [LANES-1:0]   lerr_r;
  logic [LANES-1:0]   trained_r;

  assign bus.proc_mode_en         = mode_r;
  assign bus.proc_tap_sel         = tap_r;
  assign bus.proc_inc             = inc_r;
  assign bus.proc_dec             = dec_r;
  assign bus.proc_preset          = pre_r;
  assign bus.proc_init            = init_r;
  assign bus.proc_ber_timer_start = start_r;
  assign bus.proc_train_err       = terr_r;
  assign bus.proc_lock_err        = lerr_r;
  assign bus.proc_rx_trained      = trained_r;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      ktp_pstate_t      st_r;
      ktp_pkg::ktp_op_t op_r;

      // accept, wait for ready, hold until done, release until done drops
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          st_r            <= P_IDLE;
          op_r            <= ktp_pkg::KTP_OP_HOLD;
          inc_r[g]        <= 1'b0;
          dec_r[g]        <= 1'b0;
          pre_r[g]        <= 1'b0;
          init_r[g]       <= 1'b0;
          usr_cmd_busy[g] <= 1'b0;
          usr_cmd_ack[g]  <= 1'b0;
        end else if (ce) begin
          usr_cmd_ack[g] <= 1'b0;
          unique case (st_r)
            P_IDLE: begin
              if (usr_cmd_valid[g] && usr_cmd_op[g] != ktp_pkg::KTP_OP_HOLD) begin
                op_r            <= usr_cmd_op[g];
                usr_cmd_busy[g] <= 1'b1;
                st_r            <= P_WAIT_RDY;
              end
            end
            P_WAIT_RDY: begin
              if (bus.core_cmd_ready[g]) begin
                inc_r[g]  <= (op_r == ktp_pkg::KTP_OP_INC);
                dec_r[g]  <= (op_r == ktp_pkg::KTP_OP_DEC);
                pre_r[g]  <= (op_r == ktp_pkg::KTP_OP_PRESET);
                init_r[g] <= (op_r == ktp_pkg::KTP_OP_INIT);
                st_r      <= P_HOLD;
              end
            end
            P_HOLD: begin
              if (bus.core_command_done[g]) begin
                inc_r[g]  <= 1'b0;
                dec_r[g]  <= 1'b0;
                pre_r[g]  <= 1'b0;
                init_r[g] <= 1'b0;
                st_r      <= P_RELEASE;
              end
            end
            P_RELEASE: begin
              // waiting for done to fall keeps the next command from riding the old done
              if (!bus.core_command_done[g]) begin
                usr_cmd_busy[g] <= 1'b0;
                usr_cmd_ack[g]  <= 1'b1;
                st_r            <= P_IDLE;
              end
            end
          endcase
        end
      end

      // tap select changes only between commands so the target stays put
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tap_r[g*2 +: 2] <= `KTP_TAP_NONE;
        end else if (ce && st_r == P_IDLE) begin
          tap_r[g*2 +: 2] <= usr_tap_sel[g*2 +: 2];
        end
      end

      // mode, timer start pulse and verdicts registered straight through
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mode_r[g]    <= 1'b0;
          start_r[g]   <= 1'b0;
          terr_r[g]    <= 1'b0;
          lerr_r[g]    <= 1'b0;
          trained_r[g] <= 1'b0;
        end else if (ce) begin
          mode_r[g]    <= usr_mode_en[g];
          start_r[g]   <= usr_ber_start[g];
          terr_r[g]    <= usr_train_err[g];
          lerr_r[g]    <= usr_lock_err[g];
          trained_r[g] <= usr_rx_trained[g];
        end
      end
    end
  endgenerate

endmodule : ktp_proc_end

// ### testbench/ktp_assertions.sv
// checker on the processor port signals that join the two ends
`timescale 1ns/1ps
module ktp_assertions #(
  parameter int LANES = 4,
  parameter int BCW   = 4,
  parameter int TMAX  = 16
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic [LANES-1:0]     proc_mode_en,
  input wire logic [LANES-1:0]     proc_inc,
  input wire logic [LANES-1:0]     proc_dec,
  input wire logic [LANES-1:0]     proc_preset,
  input wire logic [LANES-1:0]     proc_init,
  input wire logic [LANES-1:0]     proc_ber_timer_start,
  input wire logic [LANES-1:0]     core_cmd_ready,
  input wire logic [LANES-1:0]     core_command_done,
  input wire logic [LANES-1:0]     core_ber_timer_done,
  input wire logic [LANES*BCW-1:0] core_ber_cnt,
  input wire logic [LANES-1:0]     core_ber_overflow
);
  // done lands MAX+2 edges after start; one cycle of slack for where the edge is counted
  localparam int DLO = TMAX - 6;
  localparam int DHI = TMAX - 5;
  logic [LANES-1:0] cmd;

  // any command bit per lane
  assign cmd = proc_inc | proc_dec | proc_preset | proc_init;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // timer done stays low through the early part of a run
  sequence s_quiet;
    !core_ber_timer_done[0] [*8];
  endsequence

  property p_ready_mode;
    1'b1 |=> (core_cmd_ready & ~$past(proc_mode_en)) == '0;
  endproperty
  a_ready_mode: assert property (p_ready_mode) else $error("ready outside processor mode");
  property p_ready_take;
    (core_cmd_ready & cmd) != '0 |=> (core_cmd_ready & $past(core_cmd_ready & cmd)) == '0;
  endproperty
  a_ready_take: assert property (p_ready_take) else $error("ready held after command");
  property p_cmd_ready;
    (cmd & ~$past(cmd) & ~core_cmd_ready) == '0;
  endproperty
  a_cmd_ready: assert property (p_cmd_ready) else $error("command raised while not ready");
  property p_cmd_hold;
    cmd[0] && !core_command_done[0] |=> cmd[0];
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped before done");
  property p_done_cause;
    $rose(core_command_done[0]) |-> $past(cmd[0]);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without command");
  property p_done_drop;
    core_command_done[0] && !cmd[0] |=> !core_command_done[0];
  endproperty
  a_done_drop: assert property (p_done_drop) else $error("done held after release");
  property p_ber_done;
    $rose(proc_ber_timer_start[0]) |=> s_quiet ##[DLO:DHI] core_ber_timer_done[0];
  endproperty
  a_ber_done: assert property (p_ber_done) else $error("timer done at wrong time");
  property p_ovf_wrap;
    $rose(core_ber_overflow[0]) |->
      $past(core_ber_cnt[BCW-1:0]) == {BCW{1'b1}} && core_ber_cnt[BCW-1:0] == '0;
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow without wrap");
endmodule : ktp_assertions

// ### testbench/kr4_training_processor_port_tb.sv
// self-checking bench joining the processor end and the core end over one interface
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module kr4_training_processor_port_tb;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             ce = 1'b1;
  logic [3:0]       a_vld, a_ack, l_vld, l_ack, fl, berr, lim, p_md, t_er, k_er, r_tr;
  logic [3:0]       u_md, u_vld, u_bsy, u_ack, u_bs, u_te, u_le, u_rt;
  logic [7:0]       a_tap, l_tap, u_tap;
  ktp_pkg::ktp_op_t a_op [4];
  ktp_pkg::ktp_op_t l_op [4];
  ktp_pkg::ktp_op_t u_op [4];
  int               checked, fail_count, ack_wait, wc [4];

  always #25 clk = ~clk;

  // interface left at its defaults, which are the four-lane, four-bit-count values
  ktp_if ktp_if_i ();
  // short timer so a BER run takes under twenty cycles
  ktp_core_end #(.BER_TIMER_MAX(16'h0010)) ktp_core_end_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .bus(ktp_if_i),
    .adapt_req_valid(a_vld), .adapt_req_op(a_op), .adapt_req_tap(a_tap),
    .adapt_req_ack(a_ack), .link_req_valid(l_vld), .link_req_op(l_op), .link_req_tap(l_tap),
    .link_req_ack(l_ack), .rx_frame_lock(fl), .rx_bit_err(berr), .lp_coef_limit(lim),
    .lane_proc_mode(p_md), .lane_train_err(t_er), .lane_lock_err(k_er), .lane_rx_trained(r_tr));
  ktp_proc_end ktp_proc_end_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .bus(ktp_if_i), .usr_mode_en(u_md), .usr_tap_sel(u_tap),
    .usr_cmd_valid(u_vld), .usr_cmd_op(u_op), .usr_cmd_busy(u_bsy), .usr_cmd_ack(u_ack),
    .usr_ber_start(u_bs), .usr_train_err(u_te), .usr_lock_err(u_le), .usr_rx_trained(u_rt));
  ktp_assertions #(.LANES(4), .BCW(4), .TMAX(16)) ktp_assertions_i (
    .clk(clk), .rst_n(rst_n), .proc_mode_en(ktp_if_i.proc_mode_en),
    .proc_inc(ktp_if_i.proc_inc), .proc_dec(ktp_if_i.proc_dec),
    .proc_preset(ktp_if_i.proc_preset), .proc_init(ktp_if_i.proc_init),
    .proc_ber_timer_start(ktp_if_i.proc_ber_timer_start),
    .core_cmd_ready(ktp_if_i.core_cmd_ready), .core_command_done(ktp_if_i.core_command_done),
    .core_ber_timer_done(ktp_if_i.core_ber_timer_done), .core_ber_cnt(ktp_if_i.core_ber_cnt),
    .core_ber_overflow(ktp_if_i.core_ber_overflow));

  // link partner: level ack after ack_wait extra cycles, changed only at falling edges
  always @(negedge clk) begin
    for (int k = 0; k < 4; k++) begin
      wc[k] = l_vld[k] ? wc[k] + 1 : 0;
      l_ack[k] <= l_vld[k] && (wc[k] > ack_wait);
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  // one processor command on lane k, entered at a falling edge with the lane idle
  task automatic do_cmd(input int k, input ktp_pkg::ktp_op_t op, input logic [1:0] tap,
                        input logic lnk);
    logic seen;
    seen = 1'b0;
    u_tap[k*2+:2] = tap;
    u_op[k] = op;
    u_vld[k] = 1'b1;
    @(negedge clk);
    u_vld[k] = 1'b0;
    `CHK("busy", 1'b1, u_bsy[k])
    for (int i = 0; i < 60 && !u_ack[k]; i++) begin
      @(negedge clk);
      if (l_vld[k] && !seen) begin
        seen = 1'b1;
        `CHK("link op", op, l_op[k])
        `CHK("bus tap", tap, ktp_if_i.proc_tap_sel[k*2+:2])
        `CHK("other lanes", 4'h0, l_vld & ~(4'h1 << k))
        if (op == ktp_pkg::KTP_OP_INC || op == ktp_pkg::KTP_OP_DEC)
          `CHK("link tap", tap, l_tap[k*2+:2])
      end
    end
    `CHK("cmd ack", 1'b1, u_ack[k])
    `CHK("link used", lnk, seen)
  endtask : do_cmd

  // BER run on lane 0 with n errors starting in the start cycle of the core
  task automatic ber_run(input int n, input logic [3:0] ec, input logic ov);
    u_bs[0] = 1'b1;
    @(negedge clk);
    u_bs[0] = 1'b0;
    berr[0] = 1'b1;
    repeat (n) @(negedge clk);
    berr[0] = 1'b0;
    for (int i = 0; i < 40 && !ktp_if_i.core_ber_timer_done[0]; i++) @(negedge clk);
    `CHK("timer done", 1'b1, ktp_if_i.core_ber_timer_done[0])
    `CHK("err count", ec, ktp_if_i.core_ber_cnt[3:0])
    `CHK("overflow", ov, ktp_if_i.core_ber_overflow[0])
  endtask : ber_run

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #200us;
    fail_count++;
    end_sim();
  end

  initial begin
    {a_vld, fl, berr, lim, u_md, u_vld, u_bs, u_te, u_le, u_rt, a_tap, u_tap} = '0;
    foreach (a_op[k]) begin
      a_op[k] = ktp_pkg::KTP_OP_HOLD;
      u_op[k] = ktp_pkg::KTP_OP_HOLD;
    end
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK("ready rst", 4'h0, ktp_if_i.core_cmd_ready)
    // internal algorithm reaches the link while no lane is in processor mode
    a_op[1] = ktp_pkg::KTP_OP_INC;
    a_tap = 8'h0C;
    a_vld = 4'h2;
    @(negedge clk);
    `CHK("adapt pass", 4'h2, l_vld)
    `CHK("adapt tap", 2'h3, l_tap[3:2])
    for (int i = 0; i < 10 && !a_ack[1]; i++) @(negedge clk);
    `CHK("adapt ack", 1'b1, a_ack[1])
    a_vld = 4'h0;
    u_md = 4'hF;
    repeat (4) @(negedge clk);
    `CHK("ready", 4'hF, ktp_if_i.core_cmd_ready)
    `CHK("mode", 4'hF, p_md)
    // internal requests must not reach the link in processor mode
    a_vld = 4'h2;
    repeat (3) @(negedge clk);
    `CHK("adapt refused", 4'h0, l_vld)
    a_vld = 4'h0;
    for (int k = 0; k < 4; k++) begin
      do_cmd(k, ktp_pkg::KTP_OP_INC, 2'h1, 1'b1);
      do_cmd(k, ktp_pkg::KTP_OP_DEC, 2'h2, 1'b1);
      do_cmd(k, ktp_pkg::KTP_OP_PRESET, 2'h1, 1'b1);
      do_cmd(k, ktp_pkg::KTP_OP_INIT, 2'h1, 1'b1);
    end
    ack_wait = 4;
    do_cmd(3, ktp_pkg::KTP_OP_INC, 2'h3, 1'b1);
    ack_wait = 0;
    do_cmd(2, ktp_pkg::KTP_OP_DEC, 2'h0, 1'b0);
    ber_run(16, 4'h0, 1'b1);
    ber_run(3, 4'h3, 1'b0);
    // verdicts and status pass through on their own lanes
    for (int j = 0; j < 2; j++) begin
      {u_te, fl} = {2{j ? 4'hA : 4'h5}};
      {u_le, lim} = {2{j ? 4'h5 : 4'hA}};
      u_rt = j ? 4'h9 : 4'h6;
      repeat (3) @(negedge clk);
      `CHK("train err", u_te, t_er)
      `CHK("lock err", u_le, k_er)
      `CHK("rx trained", u_rt, r_tr)
      `CHK("frame lock", fl, ktp_if_i.core_frame_lock)
      `CHK("coef limit", lim, ktp_if_i.core_coef_limit)
    end
    // clock enable low: new inputs must not reach any register on either end
    ce = 1'b0;
    u_te = 4'h0;
    fl = 4'h0;
    repeat (3) @(negedge clk);
    `CHK("frozen train err", 4'hA, t_er)
    `CHK("frozen frame lock", 4'hA, ktp_if_i.core_frame_lock)
    ce = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("thawed frame lock", 4'h0, ktp_if_i.core_frame_lock)
    u_md = 4'h0;
    repeat (3) @(negedge clk);
    `CHK("ready off", 4'h0, ktp_if_i.core_cmd_ready)
    end_sim();
  end
endmodule : kr4_training_processor_port_tb
